// [rtl/pss_params.svh]
// Timing counts and clock rate for the power sequencer
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
`define PSS_CLK_MHZ          100
`define PSS_RESTART_MS       100
`define PSS_RESTART_CYC      (`PSS_RESTART_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_ON_TIME_MS       150
`define PSS_ON_TIME_CYC      (`PSS_ON_TIME_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_GOOD_DLY_MS      1
`define PSS_GOOD_DLY_CYC     (`PSS_GOOD_DLY_MS * 1000 * `PSS_CLK_MHZ + 1)
`define PSS_SKEW_MS          20
`define PSS_SKEW_CYC         (`PSS_SKEW_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_HOLDUP_MS        16
`define PSS_HOLDUP_CYC       (`PSS_HOLDUP_MS * 1000 * `PSS_CLK_MHZ + 1)
`define PSS_DEBOUNCE_CYC     100000
`endif

// [rtl/pss_pkg.sv]
// Types shared by the power sequencer
package pss_pkg;
  typedef enum logic [4:0] {
    PSS_OFF   = 5'h01,
    PSS_RAMP  = 5'h02,
    PSS_SETTL = 5'h04,
    PSS_GOOD  = 5'h08,
    PSS_FAULT = 5'h10
  } pss_state_t;

  typedef struct packed {
    logic main_rail_one_ok;
    logic main_rail_two_ok;
    logic ac_present;
    logic energy_ok;
  } pss_sense_t;

  typedef struct packed {
    logic main_rail_en;
    logic standby_rail_en;
    logic supply_good;
    logic fault;
  } pss_ctrl_t;
endpackage

// [rtl/pss_debounce.sv]
// Two-flop synchroniser and stability filter for one pin
`timescale 1ns/1ps
module pss_debounce #(
  parameter int unsigned STABLE_CYC = 100000,
  parameter logic        RESET_VAL  = 1'b1
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);
  localparam int W = $clog2(STABLE_CYC + 1);
  logic         sync1_r;
  logic         sync2_r;
  logic [W-1:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_r <= RESET_VAL;
      sync2_r <= RESET_VAL;
    end else begin
      sync1_r <= i_pin;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r   <= '0;
      o_level <= RESET_VAL;
    end else if (sync2_r == o_level) begin
      cnt_r <= '0;
    end else if (cnt_r >= W'(STABLE_CYC - 1)) begin
      cnt_r   <= '0;
      o_level <= sync2_r; // [R16]
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end
endmodule

// [rtl/pss_sequencer.sv]
// Main/standby rail sequencer with power-good generation
// Operation
// [R1] Request low enables the main rail.
// [R2] Request high or open disables the main rail.
// [R3] Standby rail stays enabled whenever AC is present.
// [R4] Accept new request after 100 ms off, even during decay.
// [R5] Short request pulses during decay never latch shutdown.
// [R6] Off longer than 100 ms: restart all rails regardless of decay.
// [R7] Request input defaults high and is debounced.
// [R8] Good high only with rails in regulation and energy stored; in GOOD, low energy_ok drops good only after hold-up AC loss.
// [R9] Good low on rail under-voltage or prolonged input loss.
// [R10] Rail in regulation within 150 ms; good 1-150 ms later.
// [R11] Good holds over 16 ms after AC loss, drops before rails.
// [R12] All main rails in regulation within 20 ms of first.
// [R13] Outputs hold regulation 17 ms after input loss.
// [R14] Regulation window is -7 percent to +5 percent of nominal.
// [R15] Good low whenever request inactive or main rail disabled.
// [R16] Debounce accepts a level after a stable cycle count.
`timescale 1ns/1ps
`include "pss_params.svh"
module pss_sequencer #(
  parameter int unsigned DEBOUNCE_CYC = `PSS_DEBOUNCE_CYC,
  parameter int unsigned RESTART_CYC  = `PSS_RESTART_CYC,
  parameter int unsigned ON_TIME_CYC  = `PSS_ON_TIME_CYC,
  parameter int unsigned GOOD_DLY_CYC = `PSS_GOOD_DLY_CYC,
  parameter int unsigned SKEW_CYC     = `PSS_SKEW_CYC,
  parameter int unsigned HOLDUP_CYC   = `PSS_HOLDUP_CYC
) (
  // Clock and reset (reset is AC application)
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  // Motherboard request pin, pulled up
  input  wire logic            i_main_on_request_n,
  // Analog comparator flags, asynchronous
  input  wire logic            i_main_rail_one_ok,
  input  wire logic            i_main_rail_two_ok,
  input  wire logic            i_ac_present,
  input  wire logic            i_energy_ok,
  // Rail enables and status
  output logic                 o_main_rail_en,
  output logic                 o_standby_rail_en,
  output logic                 o_supply_good,
  output logic                 o_fault,
  output pss_pkg::pss_state_t  o_state
);
  localparam int CW = 32;

  pss_pkg::pss_sense_t sense_s1_r;
  pss_pkg::pss_sense_t sense_r;
  pss_pkg::pss_state_t state_r;
  pss_pkg::pss_state_t state_nxt;
  logic                req_n_lvl;
  logic                req_on;
  logic [CW-1:0]       off_cnt_r;
  logic [CW-1:0]       t_cnt_r;
  logic [CW-1:0]       skew_cnt_r;
  logic [CW-1:0]       ac_cnt_r;
  logic                skew_run_r;
  logic                skew_fail_r;
  logic                rails_ok;
  logic                any_rail_ok;
  logic                ac_loss_long;
  logic                good_nxt;

  // Request pin: pull-up modelled as reset-high, then filtered
  pss_debounce #(
    .STABLE_CYC (DEBOUNCE_CYC),
    .RESET_VAL  (1'b1)
  ) u_req_db (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_main_on_request_n),
    .o_level    (req_n_lvl)
  ); // [R7]

  assign req_on = ~req_n_lvl;

  // Synchronise comparator flags (window thresholds set in analog front end)
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sense_s1_r <= '0;
      sense_r    <= '0;
    end else begin
      sense_s1_r <= '{i_main_rail_one_ok, i_main_rail_two_ok, i_ac_present, i_energy_ok};
      sense_r    <= sense_s1_r;
    end
  end

  assign rails_ok    = sense_r.main_rail_one_ok & sense_r.main_rail_two_ok; // [R14]
  assign any_rail_ok = sense_r.main_rail_one_ok | sense_r.main_rail_two_ok;

  // Time since request went inactive, saturating
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      off_cnt_r <= CW'(RESTART_CYC);
    end else if (req_on) begin
      off_cnt_r <= '0;
    end else if (off_cnt_r < CW'(RESTART_CYC)) begin
      off_cnt_r <= off_cnt_r + CW'(1);
    end
  end

  // AC loss timer: good must survive the first part of a dropout
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ac_cnt_r <= '0;
    end else if (sense_r.ac_present) begin
      ac_cnt_r <= '0;
    end else if (ac_cnt_r < CW'(HOLDUP_CYC)) begin
      ac_cnt_r <= ac_cnt_r + CW'(1);
    end
  end

  // Loss beyond hold-up with stored energy too low ends guarantee
  assign ac_loss_long = (ac_cnt_r >= CW'(HOLDUP_CYC)) & ~sense_r.energy_ok; // [R11] [R13]

  // Rail arrival skew watch: starts when the first rail arrives
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      skew_cnt_r  <= '0;
      skew_run_r  <= 1'b0;
      skew_fail_r <= 1'b0;
    end else if (state_r != pss_pkg::PSS_RAMP) begin
      skew_cnt_r  <= '0;
      skew_run_r  <= 1'b0;
      skew_fail_r <= 1'b0;
    end else if (any_rail_ok && !rails_ok) begin
      skew_run_r <= 1'b1;
      if (skew_cnt_r >= CW'(SKEW_CYC)) begin
        skew_fail_r <= 1'b1; // [R12]
      end else begin
        skew_cnt_r <= skew_cnt_r + CW'(1);
      end
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pss_pkg::PSS_OFF: begin
        if (req_on) begin
          state_nxt = pss_pkg::PSS_RAMP; // [R1]
        end
      end
      pss_pkg::PSS_RAMP: begin
        if (!req_on) begin
          state_nxt = pss_pkg::PSS_OFF; // [R2]
        end else if (skew_fail_r || t_cnt_r >= CW'(ON_TIME_CYC)) begin
          state_nxt = pss_pkg::PSS_FAULT; // [R10]
        end else if (rails_ok) begin
          state_nxt = pss_pkg::PSS_SETTL;
        end
      end
      pss_pkg::PSS_SETTL: begin
        if (!req_on) begin
          state_nxt = pss_pkg::PSS_OFF;
        end else if (!rails_ok) begin
          state_nxt = pss_pkg::PSS_RAMP;
        end else if (t_cnt_r >= CW'(GOOD_DLY_CYC - 1) && sense_r.energy_ok) begin
          state_nxt = pss_pkg::PSS_GOOD; // [R10]
        end
      end
      pss_pkg::PSS_GOOD: begin
        if (!req_on) begin
          state_nxt = pss_pkg::PSS_OFF;
        end else if (!rails_ok) begin
          state_nxt = pss_pkg::PSS_FAULT; // [R9]
        end
      end
      pss_pkg::PSS_FAULT: begin
        // Cleared by an off period of the full restart time
        if (!req_on && off_cnt_r >= CW'(RESTART_CYC)) begin
          state_nxt = pss_pkg::PSS_OFF; // [R4]
        end
      end
      default: begin
        state_nxt = pss_pkg::PSS_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= pss_pkg::PSS_OFF;
    end else begin
      // OFF re-enters RAMP at any decay point; short pulses never fault
      state_r <= state_nxt; // [R5] [R6]
    end
  end

  // Phase timer: restarts on every state change
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      t_cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      t_cnt_r <= '0;
    end else if (t_cnt_r < CW'(ON_TIME_CYC)) begin
      t_cnt_r <= t_cnt_r + CW'(1);
    end
  end

  // Good only in GOOD, with request, rails in regulation and no long AC loss
  assign good_nxt = (state_nxt == pss_pkg::PSS_GOOD) & req_on & rails_ok
                    & ~ac_loss_long; // [R8] [R9] [R15]

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_main_rail_en    <= 1'b0;
      o_standby_rail_en <= 1'b0;
      o_supply_good     <= 1'b0;
      o_fault           <= 1'b0;
      o_state           <= pss_pkg::PSS_OFF;
    end else begin
      o_main_rail_en    <= (state_nxt == pss_pkg::PSS_RAMP) ||
                           (state_nxt == pss_pkg::PSS_SETTL) ||
                           (state_nxt == pss_pkg::PSS_GOOD); // [R1] [R2]
      o_standby_rail_en <= 1'b1; // [R3]
      o_supply_good     <= good_nxt; // [R15]
      o_fault           <= (state_nxt == pss_pkg::PSS_FAULT);
      o_state           <= state_nxt;
    end
  end

  // Hold-up of the rails themselves (R13) is an analog property;
  // good falls on ac_loss_long while rails are still in regulation.
endmodule

// [sim/pss_seq_asserts.sv]
// Port checker for the power sequencer
`timescale 1ns/1ps
module pss_seq_asserts (
  // Clock, reset and inputs
  input wire logic                i_clk,
  input wire logic                i_reset_n,
  input wire logic                i_main_on_request_n,
  input wire logic                i_main_rail_one_ok,
  input wire logic                i_main_rail_two_ok,
  input wire logic                i_ac_present,
  input wire logic                i_energy_ok,
  // Outputs
  input wire logic                o_main_rail_en,
  input wire logic                o_standby_rail_en,
  input wire logic                o_supply_good,
  input wire logic                o_fault,
  input wire pss_pkg::pss_state_t o_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  stby_on_a: assert property ($past(i_reset_n) |-> o_standby_rail_en)
    else $error("standby rail off");
  en_ramp_a: assert property ($rose(o_main_rail_en) |-> o_state == pss_pkg::PSS_RAMP)
    else $error("main rail rose outside ramp");
  req_off_a: assert property (i_main_on_request_n [*8] |=> !o_main_rail_en)
    else $error("main rail on with request idle");
  good_rise_a: assert property ($rose(o_supply_good) |-> $past(i_main_rail_one_ok, 3)
    && $past(i_main_rail_two_ok, 3) && $past(i_energy_ok, 3))
    else $error("good rose without rails and energy");
  good_en_a: assert property (o_supply_good |-> o_main_rail_en)
    else $error("good high with main rail off");
  good_state_a: assert property (o_supply_good |-> o_state == pss_pkg::PSS_GOOD)
    else $error("good high outside good state");
  rail_drop_a: assert property (o_supply_good && !i_main_rail_one_ok |-> ##[1:4] !o_supply_good)
    else $error("good held after rail loss");
  hold_up_a: assert property ($fell(i_ac_present) && o_supply_good |=> o_supply_good [*8])
    else $error("good dropped early after input loss");
  fault_low_a: assert property (o_fault |-> !o_supply_good)
    else $error("good high in fault");
endmodule
bind pss_sequencer pss_seq_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_main_on_request_n(i_main_on_request_n), .i_main_rail_one_ok(i_main_rail_one_ok),
  .i_main_rail_two_ok(i_main_rail_two_ok), .i_ac_present(i_ac_present),
  .i_energy_ok(i_energy_ok), .o_main_rail_en(o_main_rail_en),
  .o_standby_rail_en(o_standby_rail_en), .o_supply_good(o_supply_good),
  .o_fault(o_fault), .o_state(o_state));

// [sim/pss_board_model.sv]
// Motherboard model driving the turn-on request pin
`timescale 1ns/1ps
module pss_board_model (
  // Clock
  input  wire logic i_clk,
  // Press command and request pin
  input  wire logic i_press,
  output logic      o_req_n
);
  // Released pin rests at the pull-up level
  always_ff @(posedge i_clk) begin
    o_req_n <= !i_press;
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  logic                i_clk, i_reset_n, press, req_n, r1_ok, r2_ok, ac_ok, en_ok;
  logic                m_en, s_en, good, fault;
  pss_pkg::pss_state_t state;
  int                  n_errors, cmp_count;
  pss_board_model u_mb (.i_clk(i_clk), .i_press(press), .o_req_n(req_n));
  pss_sequencer #(.DEBOUNCE_CYC(4), .RESTART_CYC(50), .ON_TIME_CYC(100),
    .GOOD_DLY_CYC(5), .SKEW_CYC(20), .HOLDUP_CYC(16)) u_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_main_on_request_n(req_n),
    .i_main_rail_one_ok(r1_ok), .i_main_rail_two_ok(r2_ok), .i_ac_present(ac_ok),
    .i_energy_ok(en_ok), .o_main_rail_en(m_en), .o_standby_rail_en(s_en),
    .o_supply_good(good), .o_fault(fault), .o_state(state));
  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Bounded wait for main enable, good or fault to reach v
  task automatic wait_for(input int s, input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      #1;
      if ((s == 0 ? m_en : s == 1 ? good : fault) === v) break;
      @(posedge i_clk);
    end
    wt(1);
  endtask
  task automatic t_up;
    press <= 1'b1;
    wait_for(0, 1'b1, 20);
    `CHK("ramp state", pss_pkg::PSS_RAMP, state)
    r1_ok <= 1'b1;
    r2_ok <= 1'b1;
    wt(4);
    #1 `CHK("good early", 1'b0, good)
    wait_for(1, 1'b1, 150);
    `CHK("good on", 1'b1, good)
  endtask
  task automatic t_glitch;
    press <= 1'b0;
    wt(2);
    press <= 1'b1;
    wt(12);
    #1 `CHK("main en kept", 1'b1, m_en)
  endtask
  task automatic t_drop;
    r1_ok <= 1'b0;
    wait_for(1, 1'b0, 6);
    `CHK("fault", 1'b1, fault)
    press <= 1'b0;
    r2_ok <= 1'b0;
    wait_for(2, 1'b0, 120);
    `CHK("off state", pss_pkg::PSS_OFF, state)
  endtask
  task automatic t_acloss;
    ac_ok <= 1'b0;
    en_ok <= 1'b0;
    wt(15);
    #1 `CHK("good hold", 1'b1, good)
    wait_for(1, 1'b0, 20);
    `CHK("good drop", 1'b0, good)
    ac_ok <= 1'b1;
    en_ok <= 1'b1;
  endtask
  task automatic t_decay;
    press <= 1'b0;
    wait_for(0, 1'b0, 20);
    `CHK("good off", 1'b0, good)
    r2_ok <= 1'b0;
    press <= 1'b1;
    wt(10);
    press <= 1'b0;
    wt(20);
    #1 `CHK("no latch", 1'b0, fault)
    press <= 1'b1;
    r1_ok <= 1'b0;
    wait_for(0, 1'b1, 20);
    `CHK("restart", 1'b1, m_en)
    wait_for(2, 1'b1, 130);
    `CHK("on time fault", 1'b1, fault)
  endtask
  task automatic t_skew;
    press <= 1'b0;
    wait_for(2, 1'b0, 120);
    press <= 1'b1;
    wait_for(0, 1'b1, 20);
    `CHK("restart all", 1'b1, m_en)
    r1_ok <= 1'b1;
    wait_for(2, 1'b1, 40);
    `CHK("skew fault", 1'b1, fault)
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {i_reset_n, press, r1_ok, r2_ok} = 4'h0;
    {ac_ok, en_ok} = 2'h3;
    n_errors = 0;
    cmp_count = 0;
    wt(4);
    i_reset_n <= 1'b1;
    wt(2);
    #1 `CHK("standby", 1'b1, s_en)
    `CHK("idle state", pss_pkg::PSS_OFF, state)
    wt(1);
    t_up;
    t_glitch;
    t_drop;
    t_up;
    t_acloss;
    t_decay;
    t_skew;
    results;
  end
  initial begin
    wt(5000);
    n_errors++;
    results;
  end
endmodule
